// [logic/plt_xlate.v]
// address translation unit: local routing, outbound and inbound link windows
//
// How it works
// - eight local windows route regions, no translation
// - local window sizes span 4 Kbytes to 2 GBytes
// - outbound maps 32-bit to 34-bit, adds attributes
// - nine outbound windows; window 0 is default
// - default outbound window has no base
// - base in local space, translation in link space
// - attributes hold size and request type
// - regular translation holds dest id, address bits
// - maintenance translation holds dest, hops, offset bits
// - link address is translation joined with offset
// - maintenance offset joins 12-bit field with offset
// - inbound maps 34-bit to 32-bit, adds attributes
// - five inbound windows; window 0 is default
// - default inbound window has no base
// - inbound base, translation, size and snoop
// - extra 1 Mbyte config window, programmable base
// - config hits land at same offset in config area
// - config window beats every other inbound window
// - maintenance requests carry offset, not address
`timescale 1ns/100ps
module plt_xlate (
    input wire mclk,                              // 10 MHz clock
    input wire arst_n,                            // async reset, active low
    input wire lcl_valid,                         // local master access strobe
    input wire [31:0] lcl_addr,                   // local address
    input wire lcl_write,                         // access is a write
    input wire [8*20-1:0] local_routing_window,   // window bases, bits 31:12 each
    input wire [8*5-1:0] lw_size,                 // window size codes
    input wire [7:0] lw_en,                       // window enables
    input wire [8*4-1:0] lw_target,               // target interface per window
    input wire [11:0] config_area_base_reg,       // config area base, bits 31:20
    input wire [19:0] onchip_sram_base_reg,       // sram base, bits 31:12
    input wire [4:0] sram_size,                   // sram region size code
    input wire sram_en,                           // sram region enabled
    output reg lcl_done,                          // decode result valid
    output reg [3:0] lcl_target,                  // chosen target interface
    output reg [2:0] lcl_win,                     // matching local window
    output reg lcl_cfg,                           // hit config area
    output reg lcl_sram,                          // hit on-chip sram
    output reg lcl_miss,                          // no window covers address
    input wire [8*20-1:0] outbound_base_reg,      // windows 1..8, bits 31:12
    input wire [7:0] ob_en,                       // enables for windows 1..8
    input wire [9*32-1:0] outbound_translation_reg, // windows 0..8
    input wire [9*32-1:0] outbound_attributes_reg,  // windows 0..8
    output reg ob_valid,                          // link request strobe
    output reg ob_write,                          // request is a write
    output reg [33:0] ob_link_addr,               // translated link address
    output reg [7:0] ob_dest_id,                  // target device id
    output reg [7:0] ob_hop,                      // hop count, maintenance
    output reg [23:0] ob_maint_off,               // maintenance register offset
    output reg ob_maint,                          // request is maintenance
    output reg [3:0] ob_ttype,                    // request type code
    output reg [1:0] ob_prio,                     // request priority
    output reg [3:0] ob_win,                      // outbound window used
    input wire in_valid,                          // incoming link access strobe
    input wire [33:0] in_addr,                    // link address
    input wire in_write,                          // incoming write
    input wire [4*22-1:0] inbound_base_reg,       // windows 1..4, bits 33:12
    input wire [3:0] ib_en,                       // enables for windows 1..4
    input wire [5*20-1:0] inbound_translation_reg,  // windows 0..4, bits 31:12
    input wire [5*32-1:0] inbound_attributes_reg,   // windows 0..4
    input wire [13:0] config_space_window_base_reg, // link base, bits 33:20
    input wire cfg_win_en,                        // config window enabled
    output reg ib_valid,                          // translated access strobe
    output reg ib_write,                          // translated access is a write
    output reg [31:0] ib_local_addr,              // local address
    output reg [3:0] ib_target,                   // target interface
    output reg ib_snoop,                          // snoop local processor
    output reg ib_cfg,                            // routed to config area
    output reg [2:0] ib_win                       // inbound window used
);
    `include "plt_regs.vh"

    ////////////////////////////////////////////////////////////////////////////
    // reset release
    reg rst_meta;
    reg rst_n_s;

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n_s <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n_s <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // local routing decode
    wire [7:0] lw_hit;
    wire lw_any;
    wire [3:0] lw_idx;
    wire sram_hit;
    wire cfg_area_hit;
    wire [3:0] lw_sel_tgt;
    wire to_link;

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_lw
            plt_win_match #(.AW(32), .MAXSZ(`PLT_SZ_MAX_LCL)) u_m (
                .addr(lcl_addr),
                .base({local_routing_window[g*20 +: 20], {`PLT_PAGE_BITS{1'b0}}}),
                .size(lw_size[g*5 +: 5]),
                .en(lw_en[g]),
                .hit(lw_hit[g]),
                .mask()
            );
        end
    endgenerate

    plt_pick #(.N(8)) u_lw_pick (
        .req(lw_hit),
        .any(lw_any),
        .idx(lw_idx)
    );

    plt_win_match #(.AW(32), .MAXSZ(`PLT_SZ_MAX_LCL)) u_sram (
        .addr(lcl_addr),
        .base({onchip_sram_base_reg, {`PLT_PAGE_BITS{1'b0}}}),
        .size(sram_size),
        .en(sram_en),
        .hit(sram_hit),
        .mask()
    );

    // the config area and sram have their own bases, outside the eight windows
    assign cfg_area_hit = (lcl_addr[31:`PLT_CFG_BITS] == config_area_base_reg);
    assign lw_sel_tgt = lw_target[lw_idx[2:0]*4 +: 4];
    assign to_link = lcl_valid & ~cfg_area_hit & ~sram_hit & lw_any &
                     (lw_sel_tgt == `PLT_TGT_LINK);

    ////////////////////////////////////////////////////////////////////////////
    // outbound windows
    wire [8:0] ob_hit;
    wire [9*32-1:0] ob_mask;
    wire ob_any;
    wire [3:0] ob_pidx;
    wire [3:0] ob_sel;
    wire [31:0] ob_tr;
    wire [31:0] ob_at;
    wire [31:0] ob_m;
    wire [33:0] ob_m34;
    wire [3:0] ob_type;
    wire [33:0] next_link_addr;
    wire [23:0] next_maint_off;

    generate
        for (g = 0; g < 9; g = g + 1) begin : g_ob
            if (g == 0) begin : g_def
                // default window: size only, no base, always on
                plt_win_match #(.AW(32), .MAXSZ(`PLT_SZ_MAX_LCL)) u_m (
                    .addr(lcl_addr),
                    .base(32'h0000_0000),
                    .size(outbound_attributes_reg[`PLT_OA_SIZE_LSB +: 5]),
                    .en(1'b1),
                    .hit(ob_hit[0]),
                    .mask(ob_mask[31:0])
                );
            end else begin : g_win
                plt_win_match #(.AW(32), .MAXSZ(`PLT_SZ_MAX_LCL)) u_m (
                    .addr(lcl_addr),
                    .base({outbound_base_reg[(g-1)*20 +: 20], {`PLT_PAGE_BITS{1'b0}}}),
                    .size(outbound_attributes_reg[g*32 + `PLT_OA_SIZE_LSB +: 5]),
                    .en(ob_en[g-1]),
                    .hit(ob_hit[g]),
                    .mask(ob_mask[g*32 +: 32])
                );
            end
        end
    endgenerate

    plt_pick #(.N(8)) u_ob_pick (
        .req(ob_hit[8:1]),
        .any(ob_any),
        .idx(ob_pidx)
    );

    assign ob_sel = ob_any ? (ob_pidx + 4'h1) : 4'h0;
    assign ob_tr = outbound_translation_reg[ob_sel*32 +: 32];
    assign ob_at = outbound_attributes_reg[ob_sel*32 +: 32];
    assign ob_m = ob_mask[ob_sel*32 +: 32];
    assign ob_m34 = {2'b11, ob_m};
    assign ob_type = lcl_write ? ob_at[`PLT_OA_WR_LSB +: 4] : ob_at[`PLT_OA_RD_LSB +: 4];

    // base bits from translation, offset bits from the access
    assign next_link_addr = ({ob_tr[`PLT_TR_ADDR_W-1:0], {`PLT_PAGE_BITS{1'b0}}} & ob_m34) |
                            ({2'b00, lcl_addr} & ~ob_m34);
    assign next_maint_off = ({ob_tr[`PLT_TR_CFG_W-1:0], {`PLT_PAGE_BITS{1'b0}}} & ob_m[23:0]) |
                            (lcl_addr[23:0] & ~ob_m[23:0]);

    ////////////////////////////////////////////////////////////////////////////
    // inbound windows
    wire [4:0] ib_hit;
    wire [5*34-1:0] ib_mask;
    wire ib_any;
    wire [3:0] ib_pidx;
    wire [2:0] ib_sel;
    wire cfg_win_hit;
    wire [31:0] ib_at;
    wire [31:0] ib_m;
    wire [31:0] next_ib_addr;

    generate
        for (g = 0; g < 5; g = g + 1) begin : g_ib
            if (g == 0) begin : g_def
                plt_win_match #(.AW(34), .MAXSZ(`PLT_SZ_MAX_LINK)) u_m (
                    .addr(in_addr),
                    .base(34'h0_0000_0000),
                    .size(inbound_attributes_reg[`PLT_IA_SIZE_LSB +: 5]),
                    .en(1'b1),
                    .hit(ib_hit[0]),
                    .mask(ib_mask[33:0])
                );
            end else begin : g_win
                plt_win_match #(.AW(34), .MAXSZ(`PLT_SZ_MAX_LINK)) u_m (
                    .addr(in_addr),
                    .base({inbound_base_reg[(g-1)*22 +: 22], {`PLT_PAGE_BITS{1'b0}}}),
                    .size(inbound_attributes_reg[g*32 + `PLT_IA_SIZE_LSB +: 5]),
                    .en(ib_en[g-1]),
                    .hit(ib_hit[g]),
                    .mask(ib_mask[g*34 +: 34])
                );
            end
        end
    endgenerate

    plt_pick #(.N(4)) u_ib_pick (
        .req(ib_hit[4:1]),
        .any(ib_any),
        .idx(ib_pidx)
    );

    plt_win_match #(.AW(34), .MAXSZ(`PLT_SZ_MAX_LINK)) u_cfgwin (
        .addr(in_addr),
        .base({config_space_window_base_reg, {`PLT_CFG_BITS{1'b0}}}),
        .size(`PLT_SZ_CFG),
        .en(cfg_win_en),
        .hit(cfg_win_hit),
        .mask()
    );

    assign ib_sel = ib_any ? (ib_pidx[2:0] + 3'h1) : 3'h0;
    assign ib_at = inbound_attributes_reg[ib_sel*32 +: 32];
    assign ib_m = ib_mask[ib_sel*34 +: 32];
    assign next_ib_addr = ({inbound_translation_reg[ib_sel*20 +: 20],
                           {`PLT_PAGE_BITS{1'b0}}} & ib_m) | (in_addr[31:0] & ~ib_m);

    ////////////////////////////////////////////////////////////////////////////
    // registered results, one cycle after each strobe
    always @(posedge mclk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            lcl_done <= 1'b0;
            lcl_target <= 4'h0;
            lcl_win <= 3'h0;
            lcl_cfg <= 1'b0;
            lcl_sram <= 1'b0;
            lcl_miss <= 1'b0;
            ob_valid <= 1'b0;
            ob_write <= 1'b0;
            ob_link_addr <= 34'h0_0000_0000;
            ob_dest_id <= 8'h00;
            ob_hop <= 8'h00;
            ob_maint_off <= 24'h00_0000;
            ob_maint <= 1'b0;
            ob_ttype <= 4'h0;
            ob_prio <= 2'h0;
            ob_win <= 4'h0;
            ib_valid <= 1'b0;
            ib_write <= 1'b0;
            ib_local_addr <= 32'h0000_0000;
            ib_target <= 4'h0;
            ib_snoop <= 1'b0;
            ib_cfg <= 1'b0;
            ib_win <= 3'h0;
        end else begin
            lcl_done <= lcl_valid;
            ob_valid <= to_link;
            ib_valid <= in_valid;
            if (lcl_valid) begin
                lcl_cfg <= cfg_area_hit;
                lcl_sram <= ~cfg_area_hit & sram_hit;
                lcl_miss <= ~cfg_area_hit & ~sram_hit & ~lw_any;
                lcl_win <= lw_idx[2:0];
                lcl_target <= (cfg_area_hit | sram_hit | ~lw_any) ? 4'h0 : lw_sel_tgt;
            end
            if (to_link) begin
                ob_write <= lcl_write;
                ob_win <= ob_sel;
                ob_ttype <= ob_type;
                ob_prio <= ob_at[`PLT_OA_PRIO_LSB +: 2];
                ob_dest_id <= ob_tr[`PLT_TR_DEST_LSB +: `PLT_TR_DEST_W];
                // a maintenance request carries an offset and no address
                if (ob_type == `PLT_TT_MAINT_RD || ob_type == `PLT_TT_MAINT_WR) begin
                    ob_maint <= 1'b1;
                    ob_hop <= ob_tr[`PLT_TR_HOP_LSB +: `PLT_TR_HOP_W];
                    ob_maint_off <= next_maint_off;
                    ob_link_addr <= 34'h0_0000_0000;
                end else begin
                    ob_maint <= 1'b0;
                    ob_hop <= 8'h00;
                    ob_maint_off <= 24'h00_0000;
                    ob_link_addr <= next_link_addr;
                end
            end
            if (in_valid) begin
                ib_write <= in_write;
                if (cfg_win_hit) begin
                    ib_cfg <= 1'b1;
                    ib_local_addr <= {config_area_base_reg, in_addr[`PLT_CFG_BITS-1:0]};
                    ib_target <= 4'h0;
                    ib_snoop <= 1'b0;
                    ib_win <= 3'h0;
                end else begin
                    ib_cfg <= 1'b0;
                    ib_local_addr <= next_ib_addr;
                    ib_target <= ib_at[`PLT_IA_TGT_LSB +: 4];
                    ib_snoop <= ib_at[`PLT_IA_SNOOP_BIT];
                    ib_win <= ib_sel;
                end
            end
        end
    end
endmodule

// [logic/plt_regs.vh]
// constants for the packet link address translation block
`ifndef PLT_REGS_VH
`define PLT_REGS_VH

// window size codes: region is 2^(code+1) bytes
`define PLT_SZ_W 5
`define PLT_SZ_MIN 5'h0b
`define PLT_SZ_MAX_LCL 5'h1e
`define PLT_SZ_MAX_LINK 5'h1f
`define PLT_SZ_CFG 5'h13
`define PLT_PAGE_BITS 12
`define PLT_CFG_BITS 20

// translation register layout (32 bits)
`define PLT_TR_DEST_LSB 22
`define PLT_TR_DEST_W 8
`define PLT_TR_ADDR_W 22
`define PLT_TR_HOP_LSB 12
`define PLT_TR_HOP_W 8
`define PLT_TR_CFG_W 12

// outbound attributes register layout (32 bits)
`define PLT_OA_SIZE_LSB 0
`define PLT_OA_RD_LSB 8
`define PLT_OA_WR_LSB 12
`define PLT_OA_PRIO_LSB 16

// inbound attributes register layout (32 bits)
`define PLT_IA_SIZE_LSB 0
`define PLT_IA_TGT_LSB 8
`define PLT_IA_SNOOP_BIT 12

// link request types
`define PLT_TT_NREAD 4'h2
`define PLT_TT_NWRITE 4'h4
`define PLT_TT_NWRITE_R 4'h5
`define PLT_TT_MAINT_RD 4'h8
`define PLT_TT_MAINT_WR 4'h9

// target interface code that means the packet link
`define PLT_TGT_LINK 4'hc

`endif

// [logic/plt_win_match.v]
// one address window compare: base, power-of-two size, enable
`timescale 1ns/100ps
module plt_win_match #(
    parameter AW = 32,
    parameter [4:0] MAXSZ = 5'h1e
) (
    input wire [AW-1:0] addr,     // address under test
    input wire [AW-1:0] base,     // window base, aligned to its size
    input wire [4:0] size,        // size code, 2^(size+1) bytes
    input wire en,                // window enabled
    output wire hit,              // address falls inside window
    output wire [AW-1:0] mask     // ones over the base bits
);
    `include "plt_regs.vh"

    wire [4:0] eff;
    wire [5:0] sh;

    // out-of-range codes are clamped rather than flagged
    assign eff = (size < `PLT_SZ_MIN) ? `PLT_SZ_MIN : ((size > MAXSZ) ? MAXSZ : size);
    assign sh = {1'b0, eff} + 6'h01;
    assign mask = {AW{1'b1}} << sh;
    assign hit = en & (((addr ^ base) & mask) == {AW{1'b0}});
endmodule

// [logic/plt_pick.v]
// lowest-numbered set request wins
`timescale 1ns/100ps
module plt_pick #(
    parameter N = 8
) (
    input wire [N-1:0] req,       // one bit per window
    output reg any,               // some bit set
    output reg [3:0] idx          // index of lowest set bit
);
    integer i;

    always @* begin
        any = 1'b0;
        idx = 4'h0;
        for (i = N - 1; i >= 0; i = i - 1) begin
            if (req[i]) begin
                any = 1'b1;
                idx = i[3:0];
            end
        end
    end
endmodule

// [bench/plt_xlate_props.sv]
// concurrent checks on the ports of the address translation block
`timescale 1ns/100ps
module plt_xlate_props (
    input wire mclk, // clock
    input wire arst_n, // reset, active low
    input wire lcl_valid, // local access strobe
    input wire [31:0] lcl_addr, // local address
    input wire [11:0] config_area_base_reg, // config area base
    input wire lcl_done, // decode valid
    input wire [3:0] lcl_target, // chosen target
    input wire lcl_cfg, // config area hit
    input wire lcl_sram, // sram hit
    input wire lcl_miss, // nothing covers address
    input wire ob_valid, // link request strobe
    input wire ob_maint, // maintenance request
    input wire [33:0] ob_link_addr, // link address
    input wire [7:0] ob_hop, // hop count
    input wire [23:0] ob_maint_off, // maintenance offset
    input wire [3:0] ob_ttype, // request type
    input wire in_valid, // incoming access strobe
    input wire [33:0] in_addr, // incoming link address
    input wire [13:0] config_space_window_base_reg, // config window base
    input wire cfg_win_en, // config window enable
    input wire ib_valid, // translated access strobe
    input wire [31:0] ib_local_addr, // translated address
    input wire ib_cfg // routed to config area
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////////////////
    local_done_a: assert property (lcl_done == $past(lcl_valid))
        else $error("local decode strobe not one cycle after access");
    link_route_a: assert property (ob_valid |-> lcl_done && lcl_target == 4'hc
        && !lcl_cfg && !lcl_sram && !lcl_miss) else $error("link request off link route");
    link_req_a: assert property (lcl_valid ##1 (lcl_target == 4'hc && !lcl_cfg
        && !lcl_sram && !lcl_miss) |-> ob_valid) else $error("link access gave no request");
    cfg_area_a: assert property (lcl_valid && lcl_addr[31:20] == config_area_base_reg
        |=> lcl_cfg && !lcl_miss && lcl_target == 4'h0) else $error("config area not decoded");
    maint_noaddr_a: assert property (ob_valid && ob_maint |-> ob_link_addr == 34'h0)
        else $error("maintenance request carries an address");
    maint_type_a: assert property (ob_valid |-> ob_maint == (ob_ttype == 4'h8
        || ob_ttype == 4'h9)) else $error("maintenance flag disagrees with type");
    reg_nomaint_a: assert property (ob_valid && !ob_maint |-> ob_hop == 8'h0
        && ob_maint_off == 24'h0) else $error("regular request has maintenance fields");
    reg_offset_a: assert property (ob_valid && !ob_maint
        |-> ob_link_addr[11:0] == $past(lcl_addr[11:0])) else $error("link offset lost");
    maint_offset_a: assert property (ob_valid && ob_maint
        |-> ob_maint_off[11:0] == $past(lcl_addr[11:0])) else $error("maint offset lost");
    in_done_a: assert property (ib_valid == $past(in_valid))
        else $error("inbound strobe not one cycle after access");
    in_offset_a: assert property (ib_valid |-> ib_local_addr[11:0] == $past(in_addr[11:0]))
        else $error("inbound offset lost");
    cfg_win_a: assert property (in_valid && cfg_win_en
        && in_addr[33:20] == config_space_window_base_reg |=> ib_cfg
        && ib_local_addr == {$past(config_area_base_reg), $past(in_addr[19:0])})
        else $error("config window hit not redirected");
    cover property (ob_valid && ob_maint);
    cover property (ib_valid && ib_cfg);
    cover property (lcl_done && lcl_miss);
endmodule
bind plt_xlate plt_xlate_props u_props (.mclk, .arst_n, .lcl_valid, .lcl_addr,
    .config_area_base_reg, .lcl_done, .lcl_target, .lcl_cfg, .lcl_sram, .lcl_miss, .ob_valid,
    .ob_maint, .ob_link_addr, .ob_hop, .ob_maint_off, .ob_ttype, .in_valid, .in_addr,
    .config_space_window_base_reg, .cfg_win_en, .ib_valid, .ib_local_addr, .ib_cfg);

// [bench/plt_link_peer.sv]
// remote endpoint model: takes and logs link requests
`timescale 1ns/100ps
module plt_link_peer (
    input wire mclk, // clock
    input wire arst_n, // reset, active low
    input wire ob_valid, // request strobe
    input wire [33:0] ob_link_addr, // request address
    output reg [7:0] req_cnt, // requests taken
    output reg [33:0] last_addr // address of latest request
);
    // never stalls, so every strobe is one whole request
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            req_cnt <= 8'h0;
            last_addr <= 34'h0;
        end else if (ob_valid === 1'b1) begin
            req_cnt <= req_cnt + 8'h1;
            last_addr <= ob_link_addr;
        end
    end
endmodule

// [bench/test_packet_link_address_translation.sv]
// self-checking bench for the address translation block
`timescale 1ns/100ps
module test_packet_link_address_translation;
    logic mclk = 0, arst_n = 0, lcl_valid = 0, lcl_write = 0, sram_en = 0;
    logic in_valid = 0, in_write = 0, cfg_win_en = 0;
    logic [31:0] lcl_addr = 0;
    logic [33:0] in_addr = 0;
    logic [159:0] local_routing_window = 0, outbound_base_reg = 0, inbound_attributes_reg = 0;
    logic [39:0] lw_size = 0;
    logic [7:0] lw_en = 0, ob_en = 0;
    logic [31:0] lw_target = 0;
    logic [11:0] config_area_base_reg = 0;
    logic [19:0] onchip_sram_base_reg = 0;
    logic [4:0] sram_size = 0;
    logic [287:0] outbound_translation_reg = 0, outbound_attributes_reg = 0;
    logic [87:0] inbound_base_reg = 0;
    logic [3:0] ib_en = 0;
    logic [99:0] inbound_translation_reg = 0;
    logic [13:0] config_space_window_base_reg = 0;
    wire lcl_done, lcl_cfg, lcl_sram, lcl_miss, ob_valid, ob_write, ob_maint;
    wire ib_valid, ib_write, ib_snoop, ib_cfg;
    wire [3:0] lcl_target, ob_ttype, ob_win, ib_target;
    wire [2:0] lcl_win, ib_win;
    wire [33:0] ob_link_addr, last_addr;
    wire [7:0] ob_dest_id, ob_hop, req_cnt;
    wire [23:0] ob_maint_off;
    wire [1:0] ob_prio;
    wire [31:0] ib_local_addr;
    int checked = 0, miscompares = 0;
    plt_xlate u_dut (.mclk, .arst_n, .lcl_valid, .lcl_addr, .lcl_write, .local_routing_window,
        .lw_size, .lw_en, .lw_target, .config_area_base_reg, .onchip_sram_base_reg, .sram_size,
        .sram_en, .lcl_done, .lcl_target, .lcl_win, .lcl_cfg, .lcl_sram, .lcl_miss,
        .outbound_base_reg, .ob_en, .outbound_translation_reg, .outbound_attributes_reg,
        .ob_valid, .ob_write, .ob_link_addr, .ob_dest_id, .ob_hop, .ob_maint_off, .ob_maint,
        .ob_ttype, .ob_prio, .ob_win, .in_valid, .in_addr, .in_write, .inbound_base_reg, .ib_en,
        .inbound_translation_reg, .inbound_attributes_reg, .config_space_window_base_reg,
        .cfg_win_en, .ib_valid, .ib_write, .ib_local_addr, .ib_target, .ib_snoop, .ib_cfg,
        .ib_win);
    plt_link_peer u_peer (.mclk, .arst_n, .ob_valid, .ob_link_addr, .req_cnt, .last_addr);
    always #50 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] seen, exp, input string nm);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // outputs are read 1 ns after the edge that drops the strobe
    task automatic lreq(input logic [31:0] a, input logic w);
        @(posedge mclk);
        #1 lcl_valid = 1;
        lcl_addr = a;
        lcl_write = w;
        @(posedge mclk);
        #1 lcl_valid = 0;
    endtask
    task automatic ireq(input logic [33:0] a, input logic w);
        @(posedge mclk);
        #1 in_valid = 1;
        in_addr = a;
        in_write = w;
        @(posedge mclk);
        #1 in_valid = 0;
        chk(ib_valid, 1, "ib_valid");
        chk(ib_write, w, "ib_write");
    endtask
    task automatic lchk(input logic [31:0] a, input logic [3:0] t, input logic [2:0] wn,
        input logic [2:0] f);
        lreq(a, 0);
        chk(lcl_done, 1, "lcl_done");
        chk(lcl_target, t, "lcl_target");
        chk({lcl_cfg, lcl_sram, lcl_miss}, f, "cfg_sram_miss");
        if (f == 3'b000) chk(lcl_win, wn, "lcl_win");
    endtask
    task automatic ochk(input logic [3:0] wn, tt, input logic [7:0] d, input logic [33:0] la,
        input logic [23:0] mo);
        chk(ob_valid, 1, "ob_valid");
        chk(ob_win, wn, "ob_win");
        chk(ob_ttype, tt, "ob_ttype");
        chk(ob_dest_id, d, "ob_dest_id");
        chk(ob_link_addr, la, "ob_link_addr");
        chk(ob_maint_off, mo, "ob_maint_off");
    endtask
    task automatic ichk(input logic [31:0] la, input logic [3:0] t, input logic [4:0] f);
        chk(ib_local_addr, la, "ib_local_addr");
        chk(ib_target, t, "ib_target");
        chk({ib_snoop, ib_cfg, ib_win}, f, "snoop_cfg_win");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_local;
        lchk(32'h8000_0567, 4'hc, 3'h0, 3'b000);
        lchk(32'h7fff_fffc, 4'hf, 3'h2, 3'b000);
        lchk(32'hf000_0ffc, 4'h4, 3'h7, 3'b000);
        lchk(32'hf000_1000, 4'h0, 3'h0, 3'b001);
        lchk(32'he001_2340, 4'h0, 3'h0, 3'b100);
        lchk(32'hc000_fffc, 4'h0, 3'h0, 3'b010);
        $display("test local routing done");
    endtask
    task automatic t_outbound;
        logic [7:0] n;
        lreq(32'h8100_0678, 0);
        ochk(4'h1, 4'h2, 8'h12, 34'h2_abc0_0678, 24'h0);
        chk(ob_prio, 2'h2, "ob_prio");
        lreq(32'h8104_5678, 1);
        ochk(4'h1, 4'h5, 8'h12, 34'h2_abc4_5678, 24'h0);
        @(posedge mclk) #1 chk(last_addr, 34'h2_abc4_5678, "peer_addr");
        lreq(32'h8200_1234, 1);
        ochk(4'h2, 4'h9, 8'h34, 34'h0, 24'h9a_1234);
        chk({ob_hop, ob_maint, ob_write}, {8'h05, 2'b11}, "hop_maint_write");
        lreq(32'h8200_fffc, 0);
        ochk(4'h2, 4'h8, 8'h34, 34'h0, 24'h9a_fffc);
        lreq(32'h8812_3456, 1);
        ochk(4'h0, 4'h4, 8'h77, 34'h3_c812_3456, 24'h0);
        @(posedge mclk) #1 n = req_cnt;
        lreq(32'h1000_0000, 0);
        chk(ob_valid, 0, "ob_valid");
        chk(req_cnt, n, "peer_count");
        $display("test outbound done");
    endtask
    task automatic t_inbound;
        ireq(34'h3_0001_2344, 1);
        ichk(32'h4001_2344, 4'h2, 5'b10001);
        ireq(34'h1_2345_6788, 0);
        ichk(32'he345_6788, 4'h5, 5'b00000);
        cfg_win_en = 1;
        ireq(34'h3_0001_2344, 0);
        ichk(32'he001_2344, 4'h0, 5'b01000);
        ireq(34'h3_0010_0000, 1);
        ichk(32'hc010_0000, 4'h5, 5'b00000);
        $display("test inbound done");
    endtask
    initial begin
        local_routing_window[19:0] = 20'h80000;
        local_routing_window[39:20] = 20'h80000;
        local_routing_window[159:140] = 20'hf0000;
        lw_size = {5'h0b, 20'h0, 5'h1e, 5'h0b, 5'h1b};
        lw_en = 8'h87;
        lw_target = {4'h4, 16'h0, 4'hf, 4'h1, 4'hc};
        config_area_base_reg = 12'he00;
        onchip_sram_base_reg = 20'hc0000;
        sram_size = 5'h0f;
        sram_en = 1;
        outbound_base_reg[39:0] = {20'h82000, 20'h81000};
        outbound_base_reg[159:140] = 20'h81000;
        ob_en = 8'h83;
        outbound_translation_reg[95:0] = {32'h0d00_59a7, 32'h04aa_bcde, 32'h1dfc_0000};
        outbound_attributes_reg[95:0] = {32'h0001_980f, 32'h0002_5213, 32'h0000_421b};
        outbound_attributes_reg[287:256] = 32'h0000_420b;
        inbound_base_reg[43:0] = {22'h300000, 22'h300000};
        ib_en = 4'h3;
        inbound_translation_reg[59:0] = {20'h55555, 20'h40000, 20'hc0000};
        inbound_attributes_reg[95:0] = {32'h0000_030b, 32'h0000_1213, 32'h0000_051d};
        config_space_window_base_reg = 14'h3000;
        repeat (5) @(posedge mclk);
        #1 arst_n = 1;
        repeat (3) @(posedge mclk);
        t_local();
        t_outbound();
        t_inbound();
        conclude();
    end
    initial begin
        #500000;
        miscompares++;
        conclude();
    end
endmodule
